// File: logic/cfl_main_config.sv
// Main configuration register low bits and the adjacent reserved register.
// Assumes the serial front end presents one-cycle write strobes with whole words,
// and that the pins below come from outside the clock domain.
// Behaviour
// - Pattern-select bit 12 set forces the fixed pattern onto sample and range outputs.
// - Bit 11 or the I power-down pin powers down the I channel, the pin even in extended mode.
// - Bit 10 or the Q power-down pin powers down the Q channel, the pin even in extended mode.
// - Bit 7 picks independent sampling at 0 and dual-edge interleaved sampling at 1.
// - In interleaved sampling bit 6 picks the I input at 0 and the Q input at 1.
// - In interleaved sampling bit 5 set shorts the I and Q inputs together.
// - Bit 4 picks offset binary at 0 and two's complement at 1.
// - Bit 3 set enables the time-stamp feature.
// - Register contents steer the device only in extended control mode.
`timescale 1ns/10ps
`default_nettype none
module cfl_main_config (
	input  wire logic                               i_clk_sys,        // System clock
	input  wire logic                               i_sys_rst,        // Async reset, high
	input  wire logic                               i_wr_stb,         // Write done strobe
	input  wire logic [cfl_pkg::CFL_ADDR_W-1:0]     i_wr_addr,        // Write index
	input  wire logic [cfl_pkg::CFL_DATA_W-1:0]     i_wr_data,        // Write word
	input  wire logic [cfl_pkg::CFL_ADDR_W-1:0]     i_rd_addr,        // Read index
	output logic      [cfl_pkg::CFL_DATA_W-1:0]     o_rd_data,        // Read word
	input  wire logic                               i_extended_control_mode, // Mode pin
	input  wire logic                               i_chan_i_powerdown_pin,  // I pd pin
	input  wire logic                               i_chan_q_powerdown_pin,  // Q pd pin
	output logic                                    o_fixed_pattern_select,  // Pattern out
	output logic                                    o_chan_i_powerdown,      // I powered down
	output logic                                    o_chan_q_powerdown,      // Q powered down
	output logic                                    o_low_clock_tuning,      // Low clk tune
	output logic                                    o_interleave_enable,     // DES sampling
	output logic                                    o_interleave_input_choice, // Q input
	output logic                                    o_interleave_input_short,  // Shorted
	output logic                                    o_interleave_shorted_mode, // 101b mode
	output logic                                    o_twos_complement_select,  // 2s comp
	output logic                                    o_time_stamp_enable,       // Stamp on
	output cfl_pkg::cfl_mode_t                      o_sample_mode              // Decoded mode
);
	import cfl_pkg::*;

	// Positions of the pins inside the gathered pin vector
	localparam int PIN_N    = 3;
	localparam int PIN_EXT  = 0;
	localparam int PIN_PD_I = 1;
	localparam int PIN_PD_Q = 2;

	logic [CFL_DATA_W-1:0] main_reg;
	logic [CFL_DATA_W-1:0] rsvd1_reg;
	logic [PIN_N-1:0]      pin_raw;
	logic [PIN_N-1:0]      pin_sync;
	logic                  ext_mode_sync;
	logic                  pd_i_pin_sync;
	logic                  pd_q_pin_sync;
	logic [CFL_DATA_W-1:0] eff_cfg;
	cfl_mode_t             mode_next;

	// Decode of the sampling mode from bits 7:5, shared by the mode output and the shorted-mode flag
	function automatic cfl_mode_t cfl_decode_mode(input logic [CFL_DATA_W-1:0] cfg);
		if (!cfg[CFL_BIT_INTLV])
			return CFL_MODE_INDEP;
		else if (cfg[CFL_BIT_SHORT] && !cfg[CFL_BIT_CHOICE])
			return CFL_MODE_SHORTED;
		else if (cfg[CFL_BIT_CHOICE])
			return CFL_MODE_INTLV_Q;
		else
			return CFL_MODE_INTLV_I;
	endfunction

	// Steering bits only count while interleaving, so stale bits cannot leak out
	function automatic logic cfl_intlv_bit(input logic [CFL_DATA_W-1:0] cfg, input int pos);
		return cfg[CFL_BIT_INTLV] & cfg[pos];
	endfunction

	// Pins gathered into one vector so a single loop builds every synchroniser
	assign pin_raw = {i_chan_q_powerdown_pin, i_chan_i_powerdown_pin, i_extended_control_mode};

	// Two flops per pin; the pins are asynchronous to the system clock
	for (genvar g = 0; g < PIN_N; g++) begin : g_pin_sync
		cfl_sync2 u_sync (
			.i_clk_sys (i_clk_sys),
			.i_sys_rst (i_sys_rst),
			.i_async   (pin_raw[g]),
			.o_sync    (pin_sync[g])
		);
	end

	// Named views of the synchronised pins
	assign ext_mode_sync = pin_sync[PIN_EXT];
	assign pd_i_pin_sync = pin_sync[PIN_PD_I];
	assign pd_q_pin_sync = pin_sync[PIN_PD_Q];

	// Main register: stored whole, reserved bits kept as written so read-back is honest
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			main_reg <= CFL_MAIN_RESET;
		end else if (i_wr_stb && (i_wr_addr == CFL_ADDR_MAIN)) begin
			main_reg <= i_wr_data;
		end
	end

	// Reserved register at index 1 keeps its written word
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rsvd1_reg <= CFL_RSVD1_RESET;
		end else if (i_wr_stb && (i_wr_addr == CFL_ADDR_RSVD1)) begin
			rsvd1_reg <= i_wr_data;
		end
	end

	// Read mux; unmapped indices read zero since other registers live elsewhere
	always_comb begin
		unique case (i_rd_addr)
			CFL_ADDR_MAIN:  o_rd_data = main_reg;
			CFL_ADDR_RSVD1: o_rd_data = rsvd1_reg;
			default:        o_rd_data = '0;
		endcase
	end

	// Outside extended mode the bits fall back to their reset values
	assign eff_cfg   = ext_mode_sync ? main_reg : CFL_MAIN_RESET;
	assign mode_next = cfl_decode_mode(eff_cfg);

	// Pattern select; registered one cycle after the write lands
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_fixed_pattern_select <= CFL_MAIN_RESET[CFL_BIT_PATTERN];
		end else begin
			o_fixed_pattern_select <= eff_cfg[CFL_BIT_PATTERN];
		end
	end

	// I power-down; the pin acts in either control mode
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_chan_i_powerdown <= CFL_MAIN_RESET[CFL_BIT_PD_I];
		end else begin
			o_chan_i_powerdown <= eff_cfg[CFL_BIT_PD_I] | pd_i_pin_sync;
		end
	end

	// Q power-down; the pin acts in either control mode
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_chan_q_powerdown <= CFL_MAIN_RESET[CFL_BIT_PD_Q];
		end else begin
			o_chan_q_powerdown <= eff_cfg[CFL_BIT_PD_Q] | pd_q_pin_sync;
		end
	end

	// Low clock tuning; the host decides when it suits the sampling clock
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_low_clock_tuning <= CFL_MAIN_RESET[CFL_BIT_LOWCLK];
		end else begin
			o_low_clock_tuning <= eff_cfg[CFL_BIT_LOWCLK];
		end
	end

	// Dual-edge interleaved sampling enable
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_interleave_enable <= CFL_MAIN_RESET[CFL_BIT_INTLV];
		end else begin
			o_interleave_enable <= eff_cfg[CFL_BIT_INTLV];
		end
	end

	// Input choice, held low outside interleaving
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_interleave_input_choice <= CFL_MAIN_RESET[CFL_BIT_CHOICE];
		end else begin
			o_interleave_input_choice <= cfl_intlv_bit(eff_cfg, CFL_BIT_CHOICE);
		end
	end

	// Input short, held low outside interleaving so the inputs stay apart
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_interleave_input_short <= CFL_MAIN_RESET[CFL_BIT_SHORT];
		end else begin
			o_interleave_input_short <= cfl_intlv_bit(eff_cfg, CFL_BIT_SHORT);
		end
	end

	// Shorted interleaved mode flag, only for the 101b pattern
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_interleave_shorted_mode <= 1'b0;
		end else begin
			o_interleave_shorted_mode <= (mode_next == CFL_MODE_SHORTED);
		end
	end

	// Output number format
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_twos_complement_select <= CFL_MAIN_RESET[CFL_BIT_TWOS];
		end else begin
			o_twos_complement_select <= eff_cfg[CFL_BIT_TWOS];
		end
	end

	// Time-stamp enable
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_time_stamp_enable <= CFL_MAIN_RESET[CFL_BIT_TSTAMP];
		end else begin
			o_time_stamp_enable <= eff_cfg[CFL_BIT_TSTAMP];
		end
	end

	// Decoded sampling mode, one-hot so the datapath needs no further decode
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sample_mode <= CFL_MODE_INDEP;
		end else begin
			o_sample_mode <= mode_next;
		end
	end
endmodule
`default_nettype wire

// File: logic/cfl_pkg.sv
// Constants for the converter main configuration decode block.
// Assumes a serial control port front end that delivers whole 16-bit writes.
`default_nettype none
package cfl_pkg;
	localparam int          CFL_DATA_W       = 16;
	localparam int          CFL_ADDR_W       = 4;
	// Register indices on the serial control port
	localparam logic [3:0]  CFL_ADDR_MAIN    = 4'h0;
	localparam logic [3:0]  CFL_ADDR_RSVD1   = 4'h1;
	// Values after reset
	localparam logic [15:0] CFL_MAIN_RESET   = 16'h2000;
	localparam logic [15:0] CFL_RSVD1_RESET  = 16'h2A0E;
	// Field positions in the main configuration register
	localparam int          CFL_BIT_PATTERN  = 12;
	localparam int          CFL_BIT_PD_I     = 11;
	localparam int          CFL_BIT_PD_Q     = 10;
	localparam int          CFL_BIT_RSVD9    = 9;
	localparam int          CFL_BIT_LOWCLK   = 8;
	localparam int          CFL_BIT_INTLV    = 7;
	localparam int          CFL_BIT_CHOICE   = 6;
	localparam int          CFL_BIT_SHORT    = 5;
	localparam int          CFL_BIT_TWOS     = 4;
	localparam int          CFL_BIT_TSTAMP   = 3;
	// Decoded sampling modes
	typedef enum logic [3:0] {
		CFL_MODE_INDEP   = 4'b0001,
		CFL_MODE_INTLV_I = 4'b0010,
		CFL_MODE_INTLV_Q = 4'b0100,
		CFL_MODE_SHORTED = 4'b1000
	} cfl_mode_t;
endpackage
`default_nettype wire

// File: logic/cfl_sync2.sv
// Two-flop synchroniser for a level from a pin.
// Assumes the destination runs on i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
module cfl_sync2 (
	input  wire logic i_clk_sys,  // System clock
	input  wire logic i_sys_rst,  // Async reset, active high
	input  wire logic i_async,    // Level from outside the domain
	output logic      o_sync      // Synchronised level
);
	logic meta_reg;
	// First stage read only by the second
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_reg <= 1'b0;
			o_sync   <= 1'b0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// File: sim/cfl_host_model.sv
// Host model that writes whole words through the completed-write strobe port.
// Assumes the block takes a write on the edge where the strobe is high.
`timescale 1ns/10ps
`default_nettype none
module cfl_host_model #(parameter int CLK_MHZ = 100) (
	input  wire logic        i_clk_sys,          // System clock
	output logic             o_wr_stb = 1'b0,    // Write done strobe
	output logic [3:0]       o_wr_addr = 4'h0,   // Write index
	output logic [15:0]      o_wr_data = 16'h0000 // Write word
);
	// Reserved main bits always go out at their required values; low clock tuning is set
	// at slow clocks. After the strobe the lines show junk rather than the old word.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		o_wr_stb <= 1'b1;
		o_wr_addr <= a;
		o_wr_data <= (a != 4'h0) ? d
			: (d & 16'hFDF8) | ((CLK_MHZ <= 300) ? 16'h0100 : 16'h0000);
		@(posedge i_clk_sys);
		o_wr_stb <= 1'b0;
		o_wr_addr <= ~o_wr_addr;
		o_wr_data <= ~o_wr_data;
	endtask
endmodule
`default_nettype wire

// File: sim/cfl_main_config_checker.sv
// Checker of the main configuration decode block, bound to its ports.
// Assumes a read of index 0 shows the stored main word.
`timescale 1ns/10ps
`default_nettype none
module cfl_main_config_checker (
	input wire logic i_clk_sys, i_sys_rst, i_extended_control_mode, // Clock, reset, mode
	input wire logic i_chan_i_powerdown_pin, i_chan_q_powerdown_pin, // Power-down pins
	input wire logic [3:0] i_rd_addr, // Read index
	input wire logic [15:0] o_rd_data, // Read word
	input wire logic o_fixed_pattern_select, o_chan_i_powerdown, o_chan_q_powerdown, // Controls
	input wire logic o_low_clock_tuning, o_interleave_enable, o_interleave_input_choice,
	input wire logic o_interleave_input_short, o_twos_complement_select, o_time_stamp_enable,
	input wire cfl_pkg::cfl_mode_t o_sample_mode // Decoded mode
);
	import cfl_pkg::*;
	logic [2:0] hi_cnt, lo_cnt; // Steady samples of the mode pin
	// Judge only once the synchroniser has seen a steady mode level
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hi_cnt <= 3'h0;
			lo_cnt <= 3'h0;
		end else begin
			hi_cnt <= i_extended_control_mode ? hi_cnt + {2'h0, hi_cnt != 3'h7} : 3'h0;
			lo_cnt <= i_extended_control_mode ? 3'h0 : lo_cnt + {2'h0, lo_cnt != 3'h7};
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	property follows(o, int b);
		hi_cnt > 3'h3 && $past(i_rd_addr) == 4'h0 |-> o == $past(o_rd_data[b]);
	endproperty
	sequence on_intlv;
		hi_cnt > 3'h3 && $past(i_rd_addr) == 4'h0 && $past(o_rd_data[7]);
	endsequence
	chk_pattern_follows: assert property (follows(o_fixed_pattern_select, 12))
		else $error("pattern select wrong");
	chk_pd_i_merge: assert property (hi_cnt > 3'h3 && $past(i_rd_addr) == 4'h0 |->
		o_chan_i_powerdown == ($past(o_rd_data[11]) || $past(i_chan_i_powerdown_pin, 3)))
		else $error("I pd wrong");
	chk_pd_q_pin: assert property (lo_cnt > 3'h3 |->
		o_chan_q_powerdown == $past(i_chan_q_powerdown_pin, 3)) else $error("Q pd pin ignored");
	chk_intlv_follows: assert property (follows(o_interleave_enable, 7))
		else $error("interleave wrong");
	chk_choice_intlv: assert property (on_intlv |->
		o_interleave_input_choice == $past(o_rd_data[6])) else $error("input choice wrong");
	chk_short_intlv: assert property (on_intlv |->
		o_interleave_input_short == $past(o_rd_data[5])) else $error("input short wrong");
	chk_steer_gated: assert property (hi_cnt > 3'h3 && $past(i_rd_addr) == 4'h0
		&& !$past(o_rd_data[7]) |-> !o_interleave_input_choice && !o_interleave_input_short)
		else $error("steering acts outside interleave");
	chk_format_follows: assert property (follows(o_twos_complement_select, 4))
		else $error("format wrong");
	chk_stamp_follows: assert property (follows(o_time_stamp_enable, 3))
		else $error("stamp wrong");
	chk_plain_outside: assert property (lo_cnt > 3'h3 |->
		!o_fixed_pattern_select && !o_interleave_enable
		&& !o_low_clock_tuning && o_sample_mode == CFL_MODE_INDEP) else $error("settings act outside mode");
	cover property (o_sample_mode == CFL_MODE_SHORTED);
	cover property (o_sample_mode == CFL_MODE_INTLV_Q);
	cover property (lo_cnt > 3'h3 && o_chan_i_powerdown);
endmodule
bind cfl_main_config cfl_main_config_checker cfl_main_config_checker_inst (.*);
`default_nettype wire

// File: sim/test_cfl_main_config.sv
// Self-checking bench of the main configuration decode block.
// Assumes the host model owns the write port; the bench drives pins and read index.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_cfl_main_config;
	import cfl_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ext_pin = 1'b1, pd_i = 1'b0, pd_q = 1'b0, stb;
	logic [3:0] rd_addr = 4'h0, wa;
	logic [15:0] rd_data, wd, d, w;
	logic [9:0] outs;
	logic [13:0] exp_word;
	cfl_mode_t mode;
	logic [31:0] seed = 32'd32887;
	int errors = 0, num_checks = 0;
	logic [15:0] corner [6] = '{16'h0000, 16'h0080, 16'h00C0, 16'h00A0, 16'h00E0, 16'h1C18};
	cfl_main_config cfl_main_config_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_wr_stb(stb),
		.i_wr_addr(wa), .i_wr_data(wd), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
		.i_extended_control_mode(ext_pin), .i_chan_i_powerdown_pin(pd_i), .i_chan_q_powerdown_pin(pd_q),
		.o_fixed_pattern_select(outs[9]), .o_chan_i_powerdown(outs[8]), .o_chan_q_powerdown(outs[7]),
		.o_low_clock_tuning(outs[6]), .o_interleave_enable(outs[5]), .o_interleave_input_choice(outs[4]),
		.o_interleave_input_short(outs[3]), .o_interleave_shorted_mode(outs[2]),
		.o_twos_complement_select(outs[1]), .o_time_stamp_enable(outs[0]), .o_sample_mode(mode));
	cfl_host_model cfl_host_model_inst (.i_clk_sys(clk), .o_wr_stb(stb), .o_wr_addr(wa), .o_wr_data(wd));
	always #5 clk = ~clk; // 100 MHz
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	// Controls expected from a stored word, the mode pin and the power-down pins
	function automatic logic [13:0] exp_ctl(logic [15:0] r, logic e, logic pi, logic pq);
		logic [15:0] v;
		v = e ? r : CFL_MAIN_RESET;
		return {v[12], v[11] | pi, v[10] | pq, v[8], v[7], v[7] & v[6], v[7] & v[5],
			v[7:5] == 3'b101, v[4], v[3], !v[7] ? 4'h1 : v[6] ? 4'h4 : v[5] ? 4'h8 : 4'h2};
	endfunction
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		rd_addr <= a;
		@(posedge clk);
		#1;
	endtask
	task automatic print_verdict();
		if (errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Watchdog: the tests need under 1000 cycles, so 20000 can only mean a hang
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
	// Corner words first (every sampling mode), then random words, pins and mode level
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(4'h1);
		`CHK(rd_data, CFL_RSVD1_RESET)
		rd(4'h0);
		`CHK(rd_data, CFL_MAIN_RESET)
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			d = (i < 6) ? corner[i] : seed[15:0];
			@(posedge clk);
			ext_pin <= i < 6 || seed[16] || seed[17];
			pd_i <= seed[18] & seed[19];
			pd_q <= seed[20] & seed[21];
			cfl_host_model_inst.wr(4'h0, d);
			repeat (4) @(posedge clk);
			#1;
			w = (d & 16'hFDF8) | 16'h0100;
			exp_word = exp_ctl(w, ext_pin, pd_i, pd_q);
			`CHK(rd_data, w)
			`CHK({outs, mode}, exp_word)
		end
		cfl_host_model_inst.wr(4'h1, seed[31:16]);
		cfl_host_model_inst.wr(4'h5, 16'hFFFF);
		rd(4'h1);
		`CHK(rd_data, seed[31:16])
		rd(4'h5);
		`CHK(rd_data, 16'h0000)
		rd(4'h0);
		`CHK(rd_data, w)
		// Reset in mid-run brings the stored word and every control back
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(rd_data, CFL_MAIN_RESET)
		`CHK({outs, mode}, {10'h000, CFL_MODE_INDEP})
		@(posedge clk);
		rst <= 1'b0;
		print_verdict();
	end
endmodule
`default_nettype wire
